// [exc_prio_pkg.sv]
// shared constants for the exception priority controller
package exc_prio_pkg;
  localparam int VEC_W = 16;
  localparam int NUM_MASKABLE = 26;
  localparam int SRC_IDX_W = 5;
  // vector table occupies the top 128 bytes of the 64K space
  localparam logic [15:0] VEC_TABLE_BASE = 16'hFF80;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG = 16'hFFFA;
  localparam logic [15:0] VEC_TRAP = 16'hFFF8;
  localparam logic [15:0] VEC_SOFT_INT = 16'hFFF6;
  localparam logic [15:0] VEC_NMI = 16'hFFF4;
  localparam logic [15:0] VEC_MASKABLE_TOP = 16'hFFF2;
  localparam logic [7:0] PRIO_RESET_VAL = 8'hF2;
  localparam logic [7:0] PRIO_LOW_LIMIT = 8'hC0;
  // wishbone byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PRIO = 4'h4;
  localparam logic [3:0] REG_PEND = 4'h8;
  localparam logic [3:0] REG_ENABLE = 4'hC;
  localparam int CTRL_IMASK = 0;
  localparam int CTRL_XMASK = 1;
  localparam int CTRL_EDGE = 2;
endpackage

// [edge_latch.sv]
// edge capture latch for the external maskable request pin
`timescale 1ns/1ps
module edge_latch (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic edgeMode,
  input wire logic pinLow_n,
  input wire logic serviced,
  output logic request
);
  typedef struct packed {
    logic prevPin;
    logic latched;
  } state_t;
  state_t stateReg;
  state_t stateNext;

  always_comb begin
    stateNext = stateReg;
    stateNext.prevPin = pinLow_n;
    // a new edge in the service cycle wins over the automatic clear
    if (serviced) begin
      stateNext.latched = 1'b0;
    end
    if (edgeMode && stateReg.prevPin && !pinLow_n) begin
      stateNext.latched = 1'b1;
    end
    if (!edgeMode) begin
      stateNext.latched = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stateReg <= '{prevPin: 1'b1, latched: 1'b0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // level mode follows the pin directly
  assign request = edgeMode ? stateReg.latched : !pinLow_n;

  // the latch is a register, so a captured edge shows one cycle after the pin falls
  a_edge_capture: assert property (@(posedge clk) disable iff (!reset_n)
    edgeMode && $past(edgeMode) && $fell(pinLow_n) |=> stateReg.latched)
    else $error("edge not latched");
endmodule // edge_latch

// [prio_select.sv]
// maskable priority encoder with one promotable source
`timescale 1ns/1ps
module prio_select #(
  parameter int N = 26,
  parameter int IW = 5
) (
  input wire logic [N-1:0] active,
  input wire logic [IW-1:0] promoted,
  input wire logic promotedValid,
  output logic found,
  output logic [IW-1:0] winner
);
  always_comb begin
    found = 1'b0;
    winner = '0;
    // scan from lowest priority so index 0 (highest default) ends up winning
    for (int i = N - 1; i >= 0; i--) begin
      if (active[i]) begin
        found = 1'b1;
        winner = IW'(i);
      end
    end
    if (promotedValid && active[promoted]) begin
      winner = promoted;
    end
  end
endmodule // prio_select

// [exception_priority_controller.sv]
// exception prioritisation and vector supply for the processor core
//
// Operation
// - each exception has its own 16-bit handler vector given to the core
// - all vectors lie in the top 128 bytes of the 64K space
// - six highest vectors serve resets and non-maskable sources
// - fixed hierarchy picks among simultaneous requests; six are non-maskable
// - reset, clock monitor, watchdog, trap, software interrupt, nonmaskable pin
// - maskable requests count only while global mask bit is clear
// - global mask is set by reset and writable any time
// - priority select register promotes one maskable source to the top
// - other maskable sources keep their default order
// - promoted source still gated by global mask and local enable
// - promotion never changes any vector address
// - priority select writes accepted only while global mask is set
// - nonmaskable request pin is level sensed
// - external maskable pin selectable as level or edge sensitive
// - source gone when service begins gives the trap vector
// - edge request latched internally and cleared when serviced
// - peripheral event sources hold their request in a flag until cleared
`timescale 1ns/1ps
module exception_priority_controller #(
  parameter int NUM_SRC = exc_prio_pkg::NUM_MASKABLE
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic resetPin,
  input wire logic clockMonitorFail,
  input wire logic watchdogReset,
  input wire logic trapRequest,
  input wire logic softwareInterruptInstr,
  input wire logic nonmaskableRequestPin_n,
  input wire logic maskableRequestPin_n,
  input wire logic [NUM_SRC-2:0] peripheralEvent,
  input wire logic coreAck,
  input wire logic setGlobalMask,
  output logic requestPending,
  output logic [15:0] vectorOut,
  output logic vectorValid
);
  localparam int IW = exc_prio_pkg::SRC_IDX_W;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SERVE = 3'b010,
    ST_DONE = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    logic globalMask;
    logic xMask;
    logic edgeMode;
    logic [7:0] prioSelect;
    logic [NUM_SRC-2:0] flags;
    logic [NUM_SRC-1:0] enables;
    logic [31:0] rdData;
    logic ack;
    logic pending;
    logic [15:0] vector;
    logic vecValid;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // fixed vector of maskable source i; independent of promotion
  function automatic logic [15:0] maskableVector(input logic [IW-1:0] idx);
    maskableVector = exc_prio_pkg::VEC_MASKABLE_TOP - {10'h000, idx, 1'b0};
  endfunction

  // priority select value to source index, or invalid when out of range
  function automatic logic [IW:0] prioToIndex(input logic [7:0] val);
    logic [7:0] diff;
    diff = exc_prio_pkg::PRIO_RESET_VAL - val;
    if (val[0] || val > exc_prio_pkg::PRIO_RESET_VAL || val < exc_prio_pkg::PRIO_LOW_LIMIT) begin
      prioToIndex = '0;
    end else begin
      prioToIndex = {1'b1, diff[IW:1]};
    end
  endfunction

  // ------------------------------------------------------------
  // request gathering
  // ------------------------------------------------------------
  logic busWrite;
  logic busRead;
  logic extRequest;
  logic extServiced;
  logic [NUM_SRC-1:0] rawReq;
  logic [NUM_SRC-1:0] activeReq;
  logic [IW:0] promo;
  logic found;
  logic [IW-1:0] winner;
  logic nmiActive;
  logic nonMaskHit;
  logic [15:0] nonMaskVec;

  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !stateReg.ack;
  assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !stateReg.ack;
  assign extServiced = stateReg.fsm == ST_SERVE && coreAck && !nonMaskHit && found
    && winner == '0;

  edge_latch u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .edgeMode(stateReg.edgeMode),
    .pinLow_n(maskableRequestPin_n),
    .serviced(extServiced),
    .request(extRequest)
  );

  assign rawReq = {stateReg.flags, extRequest};
  assign activeReq = stateReg.globalMask ? '0 : (rawReq & stateReg.enables);
  assign promo = prioToIndex(stateReg.prioSelect);

  prio_select #(.N(NUM_SRC), .IW(IW)) u_prio (
    .active(activeReq),
    .promoted(promo[IW-1:0]),
    .promotedValid(promo[IW]),
    .found(found),
    .winner(winner)
  );

  assign nmiActive = !nonmaskableRequestPin_n && !stateReg.xMask;

  // fixed non-maskable hierarchy, highest first
  always_comb begin
    nonMaskHit = 1'b1;
    nonMaskVec = exc_prio_pkg::VEC_RESET;
    if (resetPin) begin
      nonMaskVec = exc_prio_pkg::VEC_RESET;
    end else if (clockMonitorFail) begin
      nonMaskVec = exc_prio_pkg::VEC_CLKMON;
    end else if (watchdogReset) begin
      nonMaskVec = exc_prio_pkg::VEC_WATCHDOG;
    end else if (trapRequest) begin
      nonMaskVec = exc_prio_pkg::VEC_TRAP;
    end else if (softwareInterruptInstr) begin
      nonMaskVec = exc_prio_pkg::VEC_SOFT_INT;
    end else if (nmiActive) begin
      nonMaskVec = exc_prio_pkg::VEC_NMI;
    end else begin
      nonMaskHit = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    stateNext.ack = 1'b0;
    stateNext.vecValid = 1'b0;
    // flags: a new event wins over a software clear in the same cycle
    if (busWrite && wb_adr_i == exc_prio_pkg::REG_PEND && wb_sel_i[0]) begin
      stateNext.flags = stateReg.flags & ~wb_dat_i[NUM_SRC-1:1];
    end
    stateNext.flags = stateNext.flags | peripheralEvent;
    if (setGlobalMask) begin
      stateNext.globalMask = 1'b1;
    end
    if (busWrite) begin
      stateNext.ack = 1'b1;
      case (wb_adr_i)
        exc_prio_pkg::REG_CTRL: begin
          if (wb_sel_i[0]) begin
            stateNext.globalMask = wb_dat_i[exc_prio_pkg::CTRL_IMASK];
            stateNext.xMask = wb_dat_i[exc_prio_pkg::CTRL_XMASK];
            stateNext.edgeMode = wb_dat_i[exc_prio_pkg::CTRL_EDGE];
          end
        end
        exc_prio_pkg::REG_PRIO: begin
          if (wb_sel_i[0] && stateReg.globalMask) begin
            stateNext.prioSelect = wb_dat_i[7:0];
          end
        end
        exc_prio_pkg::REG_ENABLE: begin
          if (wb_sel_i[0]) begin
            stateNext.enables = wb_dat_i[NUM_SRC-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (busRead) begin
      stateNext.ack = 1'b1;
      case (wb_adr_i)
        exc_prio_pkg::REG_CTRL: stateNext.rdData = {29'h0, stateReg.edgeMode, stateReg.xMask,
          stateReg.globalMask};
        exc_prio_pkg::REG_PRIO: stateNext.rdData = {24'h0, stateReg.prioSelect};
        exc_prio_pkg::REG_PEND: stateNext.rdData = 32'(rawReq);
        exc_prio_pkg::REG_ENABLE: stateNext.rdData = 32'(stateReg.enables);
        default: stateNext.rdData = 32'h0;
      endcase
    end
    stateNext.pending = nonMaskHit || found;
    case (stateReg.fsm)
      ST_IDLE: begin
        if (nonMaskHit || found) begin
          stateNext.fsm = ST_SERVE;
        end
      end
      ST_SERVE: begin
        if (coreAck) begin
          stateNext.vecValid = 1'b1;
          stateNext.fsm = ST_DONE;
          if (nonMaskHit) begin
            stateNext.vector = nonMaskVec;
          end else if (found) begin
            stateNext.vector = maskableVector(winner);
          end else begin
            // request vanished before service began
            stateNext.vector = exc_prio_pkg::VEC_TRAP;
          end
          if (!nonMaskHit && found && winner != '0) begin
            stateNext.flags[winner - IW'(1)] = 1'b0;
          end
          // entering a handler inhibits further maskable interrupts
          stateNext.globalMask = 1'b1;
        end
      end
      ST_DONE: begin
        if (!coreAck) begin
          stateNext.fsm = ST_IDLE;
        end
      end
      default: stateNext.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stateReg.fsm <= ST_IDLE;
      stateReg.globalMask <= 1'b1;
      stateReg.xMask <= 1'b1;
      stateReg.edgeMode <= 1'b0;
      stateReg.prioSelect <= exc_prio_pkg::PRIO_RESET_VAL;
      stateReg.flags <= '0;
      stateReg.enables <= '0;
      stateReg.rdData <= 32'h0;
      stateReg.ack <= 1'b0;
      stateReg.pending <= 1'b0;
      stateReg.vector <= exc_prio_pkg::VEC_RESET;
      stateReg.vecValid <= 1'b0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign wb_dat_o = stateReg.rdData;
  assign wb_ack_o = stateReg.ack;
  assign requestPending = stateReg.pending;
  assign vectorOut = stateReg.vector;
  assign vectorValid = stateReg.vecValid;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_mask_reset: assert property (@(posedge clk)
    !reset_n |=> stateReg.globalMask)
    else $error("global mask not set after reset");
  a_prio_locked: assert property (@(posedge clk) disable iff (!reset_n)
    busWrite && wb_adr_i == exc_prio_pkg::REG_PRIO && !stateReg.globalMask
    |=> $stable(stateReg.prioSelect))
    else $error("priority select written while unmasked");
  // checked at the registered output so a broken gate cannot hide in the encoder
  a_mask_gates: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.globalMask && !nonMaskHit |=> !requestPending)
    else $error("maskable request seen while masked");
  a_reset_first: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && resetPin
    |=> vectorValid && vectorOut == 16'hFFFE)
    else $error("reset not top priority");
  a_nmi_vector: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && nmiActive && !resetPin && !clockMonitorFail
    && !watchdogReset && !trapRequest && !softwareInterruptInstr
    |=> vectorOut == 16'hFFF4)
    else $error("nonmaskable pin vector wrong");
  a_trap_empty: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && !nonMaskHit && !found
    |=> vectorOut == 16'hFFF8)
    else $error("trap vector not taken");
  a_vec_range: assert property (@(posedge clk) disable iff (!reset_n)
    vectorValid |-> vectorOut >= exc_prio_pkg::VEC_TABLE_BASE && !vectorOut[0])
    else $error("vector outside table");
  a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
    peripheralEvent[0] |=> stateReg.flags[0])
    else $error("flag event lost");
  a_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
    busWrite && wb_adr_i == exc_prio_pkg::REG_PEND && wb_sel_i[0] && wb_dat_i[1]
    && !peripheralEvent[0] |=> !stateReg.flags[0])
    else $error("flag not cleared by write");
  a_wb_ack: assert property (@(posedge clk) disable iff (!reset_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");

  // ------------------------------------------------------------
  // service path checks
  // ------------------------------------------------------------
  a_valid_after_ack: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck |=> vectorValid)
    else $error("no vector after core acknowledge");
  a_vec_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    vectorValid |=> !vectorValid)
    else $error("vector valid longer than one cycle");
  // without this a pending maskable source would re-enter its handler at once
  a_serve_masks: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck |=> stateReg.globalMask)
    else $error("global mask not set on service");
  a_clkmon_order: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && !resetPin && clockMonitorFail
    |=> vectorOut == exc_prio_pkg::VEC_CLKMON)
    else $error("clock monitor not second");
  a_watchdog_order: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && !resetPin && !clockMonitorFail
    && watchdogReset |=> vectorOut == exc_prio_pkg::VEC_WATCHDOG)
    else $error("watchdog not third");
  a_nonmask_top: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && nonMaskHit
    |=> vectorOut >= exc_prio_pkg::VEC_NMI)
    else $error("non-maskable vector below the top six");
  a_maskable_low: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && !nonMaskHit && found
    |=> vectorOut < exc_prio_pkg::VEC_NMI)
    else $error("maskable vector among the top six");
  // promotion reorders service only; the vector stays tied to its source
  a_promo_vector: assert property (@(posedge clk) disable iff (!reset_n)
    stateReg.fsm == ST_SERVE && coreAck && !nonMaskHit && promo[IW]
    && activeReq[promo[IW-1:0]]
    |=> vectorOut == exc_prio_pkg::VEC_MASKABLE_TOP - {10'h000, $past(promo[IW-1:0]), 1'b0})
    else $error("promoted source not served with its own vector");
endmodule // exception_priority_controller

// [core_model.sv]
// processor core stand-in that fetches vectors from the priority controller
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic en,
  input wire logic [3:0] ackDelay,
  input wire logic requestPending,
  input wire logic vectorValid,
  input wire logic [15:0] vectorOut,
  output logic coreAck,
  output logic [15:0] lastVector,
  output logic [7:0] vecCount
);
  logic [3:0] cnt;

  // ----------------------------------------------------------------
  // vector fetch
  // ----------------------------------------------------------------
  // a long ackDelay lets the request vanish before the fetch starts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coreAck <= 1'b0;
      cnt <= 4'h0;
      lastVector <= 16'h0000;
      vecCount <= 8'h00;
    end else if (coreAck) begin
      if (vectorValid) begin
        coreAck <= 1'b0;
        lastVector <= vectorOut;
        vecCount <= vecCount + 8'h01;
      end
    end else if (!en) begin
      cnt <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      coreAck <= (cnt == 4'h1);
    end else if (requestPending) begin
      cnt <= ackDelay;
    end
  end
endmodule // core_model

// [tb.sv]
// self-checking testbench for the exception priority controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); errCount++; end end
module tb;
  logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, ackDelay = 4'h1;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, valid, pend, coreAck, en = 1'b0;
  logic [5:0] nm = 6'h00;
  logic pinN = 1'b1;
  logic setMask = 1'b0;
  logic [24:0] pe = 25'h0;
  logic [15:0] vec, lastVector;
  logic [7:0] vecCount;
  int errCount = 0, nTests = 0;

  always #5 clk = ~clk;

  exception_priority_controller u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .resetPin(nm[0]), .clockMonitorFail(nm[1]),
    .watchdogReset(nm[2]), .trapRequest(nm[3]), .softwareInterruptInstr(nm[4]),
    .nonmaskableRequestPin_n(~nm[5]), .maskableRequestPin_n(pinN),
    .peripheralEvent(pe), .coreAck(coreAck), .setGlobalMask(setMask),
    .requestPending(pend), .vectorOut(vec), .vectorValid(valid));

  core_model u_core (.clk(clk), .reset_n(reset_n), .en(en), .ackDelay(ackDelay),
    .requestPending(pend), .vectorValid(valid), .vectorOut(vec), .coreAck(coreAck),
    .lastVector(lastVector), .vecCount(vecCount));

  // ----------------------------------------------------------------
  // bus and service tasks
  // ----------------------------------------------------------------
  task automatic giveVerdict();
    if (errCount == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin errCount++; giveVerdict(); end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask

  // the core is only let loose for one fetch so stale requests are not consumed
  task automatic serve(input logic [15:0] e, input string nm);
    logic [7:0] c0;
    int n;
    c0 = vecCount;
    en <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (vecCount === c0 && n < 60);
    en <= 1'b0;
    if (n >= 60) begin errCount++; giveVerdict(); end
    `CHK(nm, e, lastVector)
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(4'h0, 32'h3, "ctrlReset");
    rd(4'h4, 32'hF2, "prioReset");
    rd(4'hC, 32'h0, "enableReset");
    rd(4'h2, 32'h0, "unmapped");
    // fixed order among the six unmaskable sources, lowest first
    wb(1'b1, 4'h0, 32'h1);
    for (int i = 5; i >= 0; i--) begin
      nm <= 6'h3F << i;
      serve(16'hFFFE - 16'(2 * i), "nmVector");
    end
    nm <= 6'h00;
    // maskable sources 3, 5, 7 flagged by one-cycle events
    wb(1'b1, 4'h0, 32'h3);
    wb(1'b1, 4'hC, 32'h3FFFFFF);
    pe <= 25'h54;
    @(posedge clk);
    pe <= 25'h0;
    rd(4'h8, 32'hA8, "flagsHeld");
    wb(1'b1, 4'h4, 32'hE4);
    rd(4'h4, 32'hE4, "prioWrite");
    repeat (6) @(posedge clk);
    `CHK("maskedPend", 1'b0, pend)
    wb(1'b1, 4'h0, 32'h2);
    wb(1'b1, 4'h4, 32'hF0);
    rd(4'h4, 32'hE4, "prioLocked");
    serve(16'hFFE4, "promoted");
    wb(1'b1, 4'h0, 32'h2);
    serve(16'hFFEC, "defaultOrder");
    // promote source 5 but withdraw its enable; source 9 must win
    wb(1'b1, 4'h0, 32'h3);
    wb(1'b1, 4'h4, 32'hE8);
    wb(1'b1, 4'hC, 32'h3FFFFDF);
    pe <= 25'h100;
    @(posedge clk);
    pe <= 25'h0;
    wb(1'b1, 4'h0, 32'h2);
    serve(16'hFFE0, "promotedGated");
    wb(1'b1, 4'h0, 32'h3);
    wb(1'b1, 4'h8, 32'hFFFFFFFF);
    rd(4'h8, 32'h0, "flagsCleared");
    // edge mode: short low pulse must be remembered
    wb(1'b1, 4'hC, 32'h1);
    wb(1'b1, 4'h0, 32'h6);
    pinN <= 1'b0;
    @(posedge clk);
    pinN <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("edgeLatched", 1'b1, pend)
    serve(16'hFFF2, "edgeVector");
    wb(1'b1, 4'h0, 32'h6);
    repeat (3) @(posedge clk);
    `CHK("edgeCleared", 1'b0, pend)
    // level mode: request withdrawn before a slow core fetches
    wb(1'b1, 4'h0, 32'h2);
    ackDelay <= 4'h6;
    pinN <= 1'b0;
    for (int n = 0; n < 20 && pend !== 1'b1; n++) @(posedge clk);
    pinN <= 1'b1;
    serve(16'hFFF8, "trapVector");
    // core side mask set while software has the mask clear
    wb(1'b1, 4'h0, 32'h2);
    setMask <= 1'b1;
    @(posedge clk);
    setMask <= 1'b0;
    rd(4'h0, 32'h3, "coreMaskSet");
    giveVerdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    giveVerdict();
  end
endmodule // tb
